// >>> design/charge_thermal_safety_timer_ctrl.sv
`timescale 1ns/1ps
module charge_thermal_safety_timer_ctrl
   import chg_safety_pkg::*;
#(
   parameter longint low_batt_cycles = longint'(low_batt_hours) * sec_per_hour * clk_hz,
   parameter longint long_cycles     = longint'(long_hours) * sec_per_hour * clk_hz,
   parameter longint short_cycles    = longint'(short_hours) * sec_per_hour * clk_hz
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire temp_cmp_t   temp_cmp,
   input  wire reg_loop_t   loops,
   input  wire logic        charge_enable_pin_n,
   output chg_drive_t       drive,
   output logic             host_interrupt_n
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic zone_t decode_zone(input temp_cmp_t c);
      if (!c.above_t4 || c.above_t1) begin
         decode_zone = zone_out;
      end else if (c.above_t2) begin
         decode_zone = zone_cool;
      end else if (!c.above_t3) begin
         decode_zone = zone_warm;
      end else begin
         decode_zone = zone_normal;
      end
   endfunction

   function automatic logic [31:0] pad(input logic [15:0] v);
      pad = {16'h0000, v};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [ctl_width-1:0] ctl_reg, ctl_next;
   logic [31:0]          prdata_reg, prdata_next;
   logic                 pready_reg, pready_next;
   logic                 pslverr_reg, pslverr_next;
   chg_state_t           state_reg, state_next;
   logic [timer_w-1:0]   timer_reg, timer_next;
   logic                 half_reg, half_next;
   logic [1:0]           fault_reg, fault_next;
   logic [2:0]           ntc_reg, ntc_next;
   logic [2:0]           src_reg, src_next;
   logic [2:0]           flags_reg, flags_next;
   chg_drive_t           drive_reg, drive_next;
   logic                 en_prev_reg, en_prev_next;
   logic [15:0]          irq_cnt_reg, irq_cnt_next;
   logic                 irq_n_reg, irq_n_next;
   zone_t                zone_reg, zone_next;

   logic                 enabled;
   logic                 restart_req;
   logic                 expire;
   logic [timer_w-1:0]   limit;
   logic                 qual;
   zone_t                zone_eff;

   // ----------------------------------------------------------------
   // APB slave and control register
   // ----------------------------------------------------------------
   always_comb begin
      ctl_next     = ctl_reg;
      prdata_next  = prdata_reg;
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      restart_req  = 1'b0;
      if (psel && !penable) begin
         pready_next = 1'b1;
         prdata_next = 32'h0000_0000;
         unique case (paddr)
            ctrl_off:   prdata_next = pad({7'h00, ctl_reg});
            status_off: prdata_next = pad({3'h0, zone_reg, flags_reg, src_reg, ntc_reg, fault_reg});
            timer_off:  prdata_next = timer_reg[timer_w-1:timer_w-32];
            input_off:  prdata_next = pad({10'h000, temp_cmp});
            default:    pslverr_next = 1'b1;
         endcase
      end
      // Writes land at the access edge, where the master sees pready high.
      if (psel && penable && pready_reg && pwrite && paddr == ctrl_off) begin
         ctl_next = pwdata[ctl_width-1:0];
         ctl_next[ctl_restart] = 1'b0;
         // A self-clearing restart request.
         restart_req = pwdata[ctl_restart];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg     <= ctl_reset;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         ctl_reg     <= ctl_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ----------------------------------------------------------------
   // Charge control and safety timer
   // ----------------------------------------------------------------
   always_comb begin
      qual      = ctl_reg[ctl_qual_en];
      zone_next = decode_zone(temp_cmp);
      zone_eff  = qual ? zone_reg : zone_normal;
      enabled   = ctl_reg[ctl_charge_config_bit] && !charge_enable_pin_n;
      if (!loops.batt_above_low) begin
         limit = timer_w'(low_batt_cycles);
      end else if (ctl_reg[ctl_fast_len]) begin
         limit = timer_w'(long_cycles);
      end else begin
         limit = timer_w'(short_cycles);
      end
      expire       = 1'b0;
      state_next   = state_reg;
      timer_next   = timer_reg;
      half_next    = half_reg;
      fault_next   = fault_reg;
      en_prev_next = enabled;
      flags_next   = {loops.min_sys_reg, loops.in_ireg, loops.in_vreg};

      unique case (state_reg)
         chg_idle: begin
            if (enabled && zone_eff != zone_out && fault_reg == fault_none &&
                !loops.other_fault && !loops.charge_done) begin
               state_next = chg_run;
               timer_next = '0;
            end
         end
         chg_run: begin
            if (zone_eff == zone_out || loops.other_fault) begin
               state_next = chg_susp;
            end else if (ctl_reg[ctl_timer_en]) begin
               if (ctl_reg[ctl_slow_en] &&
                   (loops.in_vreg || loops.in_ireg || loops.thermal_reg ||
                    zone_eff == zone_cool)) begin
                  half_next = !half_reg;
                  if (half_reg) begin
                     timer_next = timer_reg + 1'b1;
                  end
               end else begin
                  timer_next = timer_reg + 1'b1;
               end
               if (timer_reg >= limit) begin
                  state_next = chg_fault;
                  fault_next = fault_timer;
                  expire     = 1'b1;
               end
            end
            if (loops.charge_done) begin
               state_next = chg_idle;
            end
         end
         chg_susp: begin
            if (zone_eff != zone_out && !loops.other_fault) begin
               state_next = chg_run;
            end
         end
         chg_fault: begin
            state_next = chg_fault;
         end
      endcase

      // Dropping out of enable or a restart ends the cycle and its timing.
      if (!enabled || restart_req || (enabled && !en_prev_reg)) begin
         state_next = chg_idle;
         timer_next = '0;
         half_next  = 1'b0;
         fault_next = fault_none;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= chg_idle;
         timer_reg   <= '0;
         half_reg    <= 1'b0;
         fault_reg   <= fault_none;
         en_prev_reg <= 1'b0;
         flags_reg   <= 3'h0;
         zone_reg    <= zone_out;
      end else begin
         state_reg   <= state_next;
         timer_reg   <= timer_next;
         half_reg    <= half_next;
         fault_reg   <= fault_next;
         en_prev_reg <= en_prev_next;
         flags_reg   <= flags_next;
         zone_reg    <= zone_next;
      end
   end

   // ----------------------------------------------------------------
   // Drive outputs, boost temperature watch and interrupt stretcher
   // ----------------------------------------------------------------
   always_comb begin
      drive_next.charge_on      = (state_reg == chg_run);
      drive_next.use_41v        = (zone_eff == zone_warm) && ctl_reg[ctl_warm_vsel];
      if (zone_eff == zone_cool) begin
         drive_next.current_tenths = ctl_reg[ctl_cool_isel] ? ichg_fifth : ichg_half;
      end else begin
         drive_next.current_tenths = ichg_full;
      end
      ntc_next = ntc_normal;
      src_next = src_none;
      drive_next.boost_on = 1'b0;
      if (ctl_reg[ctl_boost_en]) begin
         if (!temp_cmp.above_bhot) begin
            ntc_next = ntc_hot;
         end else if (temp_cmp.above_bcold) begin
            ntc_next = ntc_cold;
         end else begin
            drive_next.boost_on = 1'b1;
            src_next            = src_otg;
         end
      end
      irq_cnt_next = irq_cnt_reg;
      irq_n_next   = irq_n_reg;
      if (expire) begin
         irq_cnt_next = 16'(irq_pulse_cycles - 1);
         irq_n_next   = 1'b0;
      end else if (irq_cnt_reg != 16'h0000) begin
         irq_cnt_next = irq_cnt_reg - 1'b1;
      end else begin
         irq_n_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_reg   <= '0;
         ntc_reg     <= ntc_normal;
         src_reg     <= src_none;
         irq_cnt_reg <= 16'h0000;
         irq_n_reg   <= 1'b1;
      end else begin
         drive_reg   <= drive_next;
         ntc_reg     <= ntc_next;
         src_reg     <= src_next;
         irq_cnt_reg <= irq_cnt_next;
         irq_n_reg   <= irq_n_next;
      end
   end

   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign drive            = drive_reg;
   assign host_interrupt_n = irq_n_reg;

endmodule // charge_thermal_safety_timer_ctrl

// >>> design/chg_safety_pkg.sv
package chg_safety_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ctrl_off   = 12'h000;
   localparam logic [11:0] status_off = 12'h004;
   localparam logic [11:0] timer_off  = 12'h008;
   localparam logic [11:0] input_off  = 12'h00c;

   // Control register field positions.
   localparam int ctl_qual_en    = 0;
   localparam int ctl_warm_vsel  = 1;
   localparam int ctl_cool_isel  = 2;
   localparam int ctl_timer_en   = 3;
   localparam int ctl_fast_len   = 4;
   localparam int ctl_slow_en    = 5;
   localparam int ctl_charge_config_bit = 6;
   localparam int ctl_restart    = 7;
   localparam int ctl_boost_en   = 8;
   localparam int ctl_width      = 9;

   localparam logic [ctl_width-1:0] ctl_reset = 9'h07d;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint clk_hz            = 200_000_000;
   localparam int     irq_pulse_us      = 256;
   localparam int     irq_pulse_cycles  = int'((longint'(irq_pulse_us) * clk_hz) / 1_000_000);
   localparam longint sec_per_hour      = 3600;
   localparam int     low_batt_hours    = 2;
   localparam int     long_hours        = 10;
   localparam int     short_hours       = 5;
   localparam int     timer_w           = 48;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] fault_none  = 2'h0;
   localparam logic [1:0] fault_timer = 2'h3;
   localparam logic [2:0] ntc_normal  = 3'h0;
   localparam logic [2:0] ntc_cold    = 3'h5;
   localparam logic [2:0] ntc_hot     = 3'h6;
   localparam logic [2:0] src_none    = 3'h0;
   localparam logic [2:0] src_otg     = 3'h7;
   localparam logic [3:0] ichg_full   = 4'ha;
   localparam logic [3:0] ichg_half   = 4'h5;
   localparam logic [3:0] ichg_fifth  = 4'h2;

   typedef enum logic [1:0] {zone_normal, zone_cool, zone_warm, zone_out} zone_t;
   typedef enum {chg_idle, chg_run, chg_susp, chg_fault} chg_state_t;

   // Comparator results from the thermistor front end: each is high while
   // the sense voltage lies above the named threshold.
   typedef struct packed {
      logic above_t1;
      logic above_t2;
      logic above_t3;
      logic above_t4;
      logic above_bcold;
      logic above_bhot;
   } temp_cmp_t;

   typedef struct packed {
      logic in_vreg;
      logic in_ireg;
      logic thermal_reg;
      logic min_sys_reg;
      logic batt_above_low;
      logic other_fault;
      logic charge_done;
   } reg_loop_t;

   typedef struct packed {
      logic       charge_on;
      logic       use_41v;
      logic [3:0] current_tenths;
      logic       boost_on;
   } chg_drive_t;

endpackage

// >>> test/charge_thermal_safety_timer_ctrl_tb.sv
`timescale 1ns/1ps
module charge_thermal_safety_timer_ctrl_tb import chg_safety_pkg::*;;
   localparam int lb = 100;
   localparam int lc = 300;
   localparam int sc = 200;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pin_n, irq_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  c1, c2;
   temp_cmp_t   temp;
   reg_loop_t   loops;
   chg_drive_t  drive;
   int          low_len, pulses, bad_count, checks_done, n;
   logic [5:0]  tz [5] = '{6'h0d, 6'h1d, 6'h05, 6'h01, 6'h3d};
   logic [5:0]  bt [4] = '{6'h0d, 6'h0c, 6'h0f, 6'h0d};
   logic [6:0]  be [4] = '{7'h78, 7'h06, 7'h05, 7'h78};
   charge_thermal_safety_timer_ctrl #(.low_batt_cycles(lb), .long_cycles(lc),
      .short_cycles(sc)) charge_thermal_safety_timer_ctrl_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .temp_cmp(temp), .loops(loops),
      .charge_enable_pin_n(pin_n), .drive(drive), .host_interrupt_n(irq_n));
   host_irq_model host_irq_model_i (.pclk(pclk), .presetn(presetn),
      .host_interrupt_n(irq_n), .len_reg(low_len), .pul_reg(pulses));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task final_report;
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task ck(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task expire(input logic [31:0] c, input reg_loop_t l, input int p, input int e);
      loops <= l;
      apb(1'b1, ctrl_off, c);
      n = 0;
      if (p > 0) begin
         repeat (50) @(posedge pclk);
         loops.other_fault <= 1'b1;
         repeat (p) @(posedge pclk);
         loops.other_fault <= 1'b0;
         n = 50 + p;
      end
      do begin
         apb(1'b0, status_off, 0);
         n += 3;
      end while (rd[1:0] !== fault_timer && n < 4 * e);
      ck(n >= e - 6 && n <= e + 20, 1);
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #400_000;
      bad_count++;
      final_report;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pin_n} = '0;
      temp = 6'h0d;
      loops = 7'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ctrl_off, 0);
      ck(rd, {23'h0, ctl_reset});
      apb(1'b0, 12'h010, 0);
      ck({err, rd[30:0]}, 32'h8000_0000);
      expire(32'h0fd, 7'h00, 0, lb);
      ck(drive.charge_on, 0);
      n = 0;
      while (irq_n !== 1'b1 && n < 60000) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
      ck(low_len, irq_pulse_cycles);
      ck(pulses, 1);
      expire(32'h0fd, 7'h04, 0, lc);
      expire(32'h0ed, 7'h04, 0, sc);
      for (int i = 0; i < 4; i++) begin
         temp <= (i == 3) ? 6'h1d : 6'h0d;
         expire(32'h0ed, reg_loop_t'((i < 3 ? 7'h40 >> i : 7'h00) | 7'h04), 0, 2 * sc);
      end
      temp <= 6'h0d;
      expire(32'h0cd, 7'h24, 0, sc);
      expire(32'h0ed, 7'h04, 100, sc + 100);
      repeat (30) @(posedge pclk);
      ck(drive.charge_on, 0);
      pin_n <= 1'b1;
      repeat (3) @(posedge pclk);
      pin_n <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, status_off, 0);
      ck(rd[1:0], fault_none);
      ck(drive.charge_on, 1);
      apb(1'b1, ctrl_off, 32'h0f5);
      repeat (2 * lc) @(posedge pclk);
      apb(1'b0, status_off, 0);
      ck(rd[1:0], fault_none);
      for (int i = 0; i < 6; i++) begin
         temp <= (i < 5) ? tz[i] : 6'h0d;
         repeat (4) @(posedge pclk);
         apb(1'b0, status_off, 0);
         ck(rd[12:11], (i < 5) ? i - (i / 4) : 0);
         ck(drive.charge_on, i < 3 || i == 5);
      end
      temp <= 6'h1d;
      repeat (4) @(posedge pclk);
      c1 = drive.current_tenths;
      apb(1'b1, ctrl_off, 32'h073);
      repeat (4) @(posedge pclk);
      c2 = drive.current_tenths;
      ck(c1 + c2, 7);
      temp <= 6'h05;
      repeat (4) @(posedge pclk);
      c1 = drive.use_41v;
      apb(1'b1, ctrl_off, 32'h075);
      repeat (4) @(posedge pclk);
      c2 = drive.use_41v;
      ck(c1 ^ c2, 1);
      apb(1'b1, ctrl_off, 32'h074);
      temp <= 6'h01;
      repeat (4) @(posedge pclk);
      ck(drive.charge_on, 1);
      temp <= 6'h1d;
      repeat (4) @(posedge pclk);
      ck(drive.current_tenths, ichg_full);
      for (int i = 0; i < 3; i++) begin
         loops <= 7'h40 >> (i + i / 2);
         repeat (3) @(posedge pclk);
         apb(1'b0, status_off, 0);
         ck(rd[10:8], 3'h1 << i);
      end
      pin_n <= 1'b1;
      loops <= 7'h00;
      apb(1'b1, ctrl_off, 32'h135);
      for (int i = 0; i < 4; i++) begin
         temp <= bt[i];
         repeat (4) @(posedge pclk);
         apb(1'b0, status_off, 0);
         ck({drive.boost_on, rd[7:2]}, be[i]);
      end
      final_report;
   end
endmodule // charge_thermal_safety_timer_ctrl_tb

// >>> test/chg_safety_asserts.sv
`timescale 1ns/1ps
module chg_safety_asserts
   import chg_safety_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire temp_cmp_t   temp_cmp,
   input wire reg_loop_t   loops,
   input wire logic        charge_enable_pin_n,
   input wire chg_drive_t  drive,
   input wire logic        host_interrupt_n
);
   // ----------------------------------------------------------------
   // Control mirror and pulse counter
   // ----------------------------------------------------------------
   logic [ctl_width-1:0] ctl_reg;
   logic [ctl_width-1:0] ctl_next;
   int                   low_reg;
   int                   low_next;
   logic                 out_w;
   logic                 cool_w;
   logic                 norm_w;
   logic                 bout_w;
   logic                 q;
   assign out_w  = !temp_cmp.above_t4 || temp_cmp.above_t1;
   assign cool_w = temp_cmp.above_t2 && !out_w;
   assign norm_w = temp_cmp.above_t3 && !temp_cmp.above_t2 && !out_w;
   assign bout_w = !temp_cmp.above_bhot || temp_cmp.above_bcold;
   assign q      = ctl_reg[ctl_qual_en];
   always_comb begin
      ctl_next = ctl_reg;
      if (psel && penable && pready && pwrite && paddr == ctrl_off) begin
         ctl_next = pwdata[ctl_width-1:0];
      end
      low_next = host_interrupt_n ? 0 : low_reg + 1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= ctl_reset;
         low_reg <= 0;
      end else begin
         ctl_reg <= ctl_next;
         low_reg <= low_next;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence out_hold;
      (q && out_w)[*3];
   endsequence
   sequence norm_hold;
      norm_w[*3];
   endsequence
   AST_OUT_STOP: assert property (out_hold |=> !drive.charge_on)
      else $error("charging outside the window");
   AST_NORM_FULL: assert property (norm_hold ##0 drive.charge_on |->
      drive.current_tenths == ichg_full) else $error("normal zone current cut");
   AST_NORM_VREG: assert property (norm_hold ##0 drive.charge_on |-> !drive.use_41v)
      else $error("normal zone voltage lowered");
   AST_COOL_CUT: assert property ((q && cool_w)[*3] ##0 drive.charge_on |->
      drive.current_tenths inside {ichg_half, ichg_fifth}) else $error("cool current");
   AST_QUAL_OFF: assert property ((!q && cool_w)[*3] ##0 drive.charge_on |->
      drive.current_tenths == ichg_full) else $error("derating while disabled");
   AST_BOOST_OUT: assert property ((ctl_reg[ctl_boost_en] && bout_w)[*3] |->
      !drive.boost_on) else $error("boost outside window");
   AST_IRQ_LOW: assert property ($fell(host_interrupt_n) |-> (!host_interrupt_n)[*8])
      else $error("interrupt pulse too short");
   AST_IRQ_WIDTH: assert property ($rose(host_interrupt_n) |->
      low_reg >= irq_pulse_cycles) else $error("interrupt pulse width");
   AST_IRQ_STOP: assert property ($fell(host_interrupt_n) |-> ##[0:2] !drive.charge_on)
      else $error("charging after expiry");
endmodule // chg_safety_asserts

bind charge_thermal_safety_timer_ctrl chg_safety_asserts chg_safety_asserts_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .temp_cmp(temp_cmp), .loops(loops), .charge_enable_pin_n(charge_enable_pin_n),
   .drive(drive), .host_interrupt_n(host_interrupt_n));

// >>> test/host_irq_model.sv
`timescale 1ns/1ps
module host_irq_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic host_interrupt_n,
   output int        len_reg,
   output int        pul_reg
);
   // ----------------------------------------------------------------
   // Host side pulse measurement
   // ----------------------------------------------------------------
   int cnt_reg;
   int cnt_next;
   int len_next;
   int pul_next;
   always_comb begin
      cnt_next = host_interrupt_n ? 0 : cnt_reg + 1;
      len_next = len_reg;
      pul_next = pul_reg;
      if (host_interrupt_n && cnt_reg != 0) begin
         len_next = cnt_reg;
         pul_next = pul_reg + 1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 0;
         len_reg <= 0;
         pul_reg <= 0;
      end else begin
         cnt_reg <= cnt_next;
         len_reg <= len_next;
         pul_reg <= pul_next;
      end
   end
endmodule // host_irq_model
